//--- core/ppmc_pkg.sv
// Purpose: Constants for the port output selection and power mode control block
// Assumes: 100 MHz system clock, single clock domain
// Notes: Register offsets are special-function addresses on the internal register port
`default_nettype none
package ppmc_pkg;
  localparam logic [7:0] PMC_ADDR = 8'h87;
  localparam logic [7:0] CFG1_ADDR = 8'hA7;
  localparam int PMC_IDLE_BIT = 0;
  localparam int PMC_PDOWN_BIT = 1;
  localparam int CFG1_UPPER_ADDR_EMIT_ENABLE_BIT = 0;
  localparam int CFG1_CSGPIO_BIT = 3;
  localparam logic [7:0] PMC_RESET = 8'h00;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 10;
  localparam int STRONG_OSC_PERIODS = 2;
  localparam int STRONG_CYCLES =
    (STRONG_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] EXT_CS_BASE = 16'h4000;
  typedef enum logic [1:0] {PPMC_ACTIVE, PPMC_IDLE, PPMC_PDOWN} ppmc_mode_t;
endpackage : ppmc_pkg
`default_nettype wire

//--- core/ppmc_strong_pulse.sv
// Purpose: Short strong-high drive window for one port bit
// Assumes: Output data from same clock domain
// Notes: After the window the pin relies on the weak pullup only
`default_nettype none
module ppmc_strong_pulse #(
  parameter int CYCLES = 2
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic bit_out, // Value being emitted
  output logic strong_en // Strong pullup active
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic prev;
  logic next_prev;
  always_comb begin
    next_prev = bit_out;
    next_cnt = cnt;
    if (bit_out && !prev) begin
      next_cnt = 4'(CYCLES);
    end else if (!bit_out) begin
      next_cnt = 4'h0;
    end else if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt <= 4'h0;
      prev <= 1'b1;
    end else begin
      cnt <= next_cnt;
      prev <= next_prev;
    end
  end
  // Rising edge already strong in its own cycle so the window is exactly CYCLES long
  assign strong_en = (bit_out && !prev) || (bit_out && cnt > 4'h1);
endmodule : ppmc_strong_pulse
`default_nettype wire

//--- core/ppmc_sync.sv
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Destination is clk_sys
// Notes: First stage is read only by the second stage
`default_nettype none
module ppmc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic [W-1:0] din, // Asynchronous level
  output logic [W-1:0] dout // Synchronised level
);
  logic [W-1:0] meta;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : ppmc_sync
`default_nettype wire

//--- core/ppmc_top.sv
// Purpose: Port one/two output selection and idle / power-down control
// Assumes: Core presents code addresses and register writes on clk_sys
// Notes: Pin inputs are synchronised; mode bits self-clear by reset, and the idle bit also on an enabled interrupt
//
// Contract
// - Internal port zero never reaches pins; it only feeds scan logic.
// - Address select high: port one carries low address byte during external access.
// - Address select low: port one keeps showing its latch value.
// - Port two carries seven upper address bits under code select or enable bit.
// - Otherwise port two shows its latch contents.
// - Pullups on all pins except LED and four serial pins, which are open drain; the code gives port two bit 7 no pullup (p2_pullup is bits 0..6).
// - During fetches a one is driven strongly two oscillator periods, then weak; the code never drives port two bit 7 strongly (p2_strong bit 7 is masked).
// - Setting power control bit 0 at 87H enters idle.
// - Idle gates CPU clock, peripheral clock keeps running.
// - Idle preserves CPU state and holds port pins at entry levels.
// - Idle holds address latch and fetch strobes high.
// - Idle ends on reset or any enabled interrupt.
// - Setting power control bit 1 enters power-down.
// - Power-down stops every clock and the crystal oscillator.
// - Power-down deasserts chip select unless configured as general I/O.
// - Power-down forces address latch and fetch strobes low.
// - RAM contents kept through power-down.
// - Power-down ends only through pin or internal reset.
// - Converter result entering idle may be invalid.
// - Code select high: chip select only at 4000H and above; low: always.
`default_nettype none
module ppmc_top #(
  parameter int STRONG_CYC = ppmc_pkg::STRONG_CYCLES
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic int_reset, // Internal reset source pulse
  input wire logic sfr_wr, // Register write strobe
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic [7:0] sfr_wdata, // Register write data
  output logic [7:0] sfr_rdata, // Register read data
  input wire logic [7:0] port_zero_latch, // Internal port zero value
  output logic [7:0] scan_drive, // Port zero to scan logic
  input wire logic [7:0] port_one_latch, // Port one register
  input wire logic [7:0] port_two_latch, // Port two register
  input wire logic ext_access, // External code access in progress
  input wire logic [15:0] ext_addr, // External code address
  input wire logic addr_is_15bit, // Access uses 15-bit address
  input wire logic ale_run, // Address latch strobe from core
  input wire logic fetch_run, // Program fetch strobe from core, active high
  input wire logic cs_gpio_out, // Chip select pin value in general I/O use
  input wire logic port1_addr_emit_select, // Pin, async
  input wire logic external_code_select_n, // Pin, async
  input wire logic irq_pending, // Enabled interrupt pending
  output logic [7:0] p1_o, // Port one pin value
  output logic [7:0] p1_strong, // Port one strong pullup enables
  output logic [7:0] p2_o, // Port two pin value
  output logic [7:0] p2_strong, // Port two strong pullup enables
  output logic [7:0] p1_pullup, // Port one weak pullup present
  output logic [6:0] p2_pullup, // Port two weak pullups, bits 0..6
  output logic port_led_pin_oe, // LED pin open drain low enable
  input wire logic port_led_drive, // LED pin latch
  input wire logic [3:0] serial_if_latch, // Serial lines latch a0,a1,b0,b1
  output logic [3:0] serial_if_oe, // Open drain low enables
  output logic ale_o, // Address latch strobe pin
  output logic program_fetch_strobe_n, // Fetch strobe pin
  output logic ext_code_chip_select_n, // Chip select pin
  output logic cpu_clk_en, // CPU clock enable
  output logic periph_clk_en, // Timer/interrupt/serial clock enable
  output logic osc_enable, // Crystal oscillator enable
  output logic adc_result_suspect, // Conversion may be invalid
  input wire logic adc_busy, // Conversion running
  output logic [1:0] mode_state // 0 active, 1 idle, 2 power-down
);
  logic [7:0] pmc;
  logic [7:0] next_pmc;
  logic [7:0] cfg1;
  logic [7:0] next_cfg1;
  logic [7:0] p1_hold;
  logic [7:0] next_p1_hold;
  logic [7:0] p2_hold;
  logic [7:0] next_p2_hold;
  logic suspect;
  logic next_suspect;
  logic [1:0] pins_s;
  logic ld_sel;
  logic eal_n;
  logic any_rst;
  logic idle;
  logic pdown;
  logic [7:0] p1_live;
  logic [7:0] p2_live;
  logic p2_addr_on;
  logic [7:0] p1_pulse;
  logic [7:0] p2_pulse;
  ppmc_pkg::ppmc_mode_t mode;

  ppmc_sync #(.W(2)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .din({port1_addr_emit_select, external_code_select_n}),
    .dout(pins_s)
  );
  assign ld_sel = pins_s[1];
  // Code select is used live, not latched at reset, so a strap change applies after the sync
  assign eal_n = pins_s[0];
  assign any_rst = int_reset;

  assign scan_drive = port_zero_latch;

  always_comb begin
    next_pmc = pmc;
    next_cfg1 = cfg1;
    next_suspect = suspect;
    if (any_rst) begin
      next_pmc = ppmc_pkg::PMC_RESET;
      next_cfg1 = ppmc_pkg::CFG1_RESET;
      next_suspect = 1'b0;
    end else begin
      if (pmc[ppmc_pkg::PMC_IDLE_BIT] && irq_pending && !pmc[ppmc_pkg::PMC_PDOWN_BIT]) begin
        next_pmc[ppmc_pkg::PMC_IDLE_BIT] = 1'b0;
      end
      if (sfr_wr && cpu_clk_en && sfr_addr == ppmc_pkg::PMC_ADDR) begin
        next_pmc = sfr_wdata;
        if (sfr_wdata[ppmc_pkg::PMC_IDLE_BIT] && adc_busy) begin
          next_suspect = 1'b1;
        end
      end
      if (sfr_wr && cpu_clk_en && sfr_addr == ppmc_pkg::CFG1_ADDR) begin
        next_cfg1 = sfr_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pmc <= ppmc_pkg::PMC_RESET;
      cfg1 <= ppmc_pkg::CFG1_RESET;
      suspect <= 1'b0;
    end else begin
      pmc <= next_pmc;
      cfg1 <= next_cfg1;
      suspect <= next_suspect;
    end
  end

  assign pdown = pmc[ppmc_pkg::PMC_PDOWN_BIT];
  assign idle = pmc[ppmc_pkg::PMC_IDLE_BIT] && !pdown;

  always_comb begin
    if (pdown) begin
      mode = ppmc_pkg::PPMC_PDOWN;
    end else if (idle) begin
      mode = ppmc_pkg::PPMC_IDLE;
    end else begin
      mode = ppmc_pkg::PPMC_ACTIVE;
    end
  end
  assign mode_state = mode;

  always_comb begin
    case (mode)
      ppmc_pkg::PPMC_ACTIVE: begin
        cpu_clk_en = 1'b1;
        periph_clk_en = 1'b1;
        osc_enable = 1'b1;
      end
      ppmc_pkg::PPMC_IDLE: begin
        cpu_clk_en = 1'b0;
        periph_clk_en = 1'b1;
        osc_enable = 1'b1;
      end
      ppmc_pkg::PPMC_PDOWN: begin
        cpu_clk_en = 1'b0;
        periph_clk_en = 1'b0;
        osc_enable = 1'b0;
      end
      default: begin
        cpu_clk_en = 1'b1;
        periph_clk_en = 1'b1;
        osc_enable = 1'b1;
      end
    endcase
  end

  // Port muxing is combinational but the pins are registered, so the address appears one cycle after the access cycle
  assign p2_addr_on = ext_access && addr_is_15bit &&
    (!eal_n || cfg1[ppmc_pkg::CFG1_UPPER_ADDR_EMIT_ENABLE_BIT]);
  always_comb begin
    p1_live = (ext_access && ld_sel) ? ext_addr[7:0] : port_one_latch;
    p2_live = p2_addr_on ? {port_two_latch[7], ext_addr[14:8]} : port_two_latch;
  end

  // Pins freeze at their entry level whenever the CPU clock is gated
  always_comb begin
    next_p1_hold = cpu_clk_en ? p1_live : p1_hold;
    next_p2_hold = cpu_clk_en ? p2_live : p2_hold;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      p1_hold <= ppmc_pkg::LATCH_RESET;
      p2_hold <= ppmc_pkg::LATCH_RESET;
    end else begin
      p1_hold <= next_p1_hold;
      p2_hold <= next_p2_hold;
    end
  end
  assign p1_o = p1_hold;
  assign p2_o = p2_hold;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_strong
      ppmc_strong_pulse #(.CYCLES(STRONG_CYC)) u_p1 (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .bit_out(p1_hold[gi]),
        .strong_en(p1_pulse[gi])
      );
      ppmc_strong_pulse #(.CYCLES(STRONG_CYC)) u_p2 (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .bit_out(p2_hold[gi]),
        .strong_en(p2_pulse[gi])
      );
    end
  endgenerate
  assign p1_strong = p1_pulse;
  assign p2_strong = p2_pulse & 8'h7F;

  assign p1_pullup = 8'hFF;
  assign p2_pullup = 7'h7F;
  assign port_led_pin_oe = !port_led_drive;
  assign serial_if_oe = ~serial_if_latch;

  always_comb begin
    if (pdown) begin
      ale_o = 1'b0;
      program_fetch_strobe_n = 1'b0;
    end else if (idle) begin
      ale_o = 1'b1;
      program_fetch_strobe_n = 1'b1;
    end else begin
      ale_o = ale_run;
      program_fetch_strobe_n = !fetch_run;
    end
  end

  always_comb begin
    if (cfg1[ppmc_pkg::CFG1_CSGPIO_BIT]) begin
      ext_code_chip_select_n = cs_gpio_out;
    end else if (pdown || idle) begin
      ext_code_chip_select_n = 1'b1;
    end else if (eal_n) begin
      ext_code_chip_select_n = !(ext_addr >= ppmc_pkg::EXT_CS_BASE);
    end else begin
      ext_code_chip_select_n = 1'b0;
    end
  end

  assign adc_result_suspect = suspect;

  always_comb begin
    case (sfr_addr)
      ppmc_pkg::PMC_ADDR: sfr_rdata = pmc;
      ppmc_pkg::CFG1_ADDR: sfr_rdata = cfg1;
      default: sfr_rdata = 8'h00;
    endcase
  end

  AST_PDOWN_STROBES: assert property (@(posedge clk_sys) disable iff (!resetn)
    pdown |-> (!ale_o && !program_fetch_strobe_n))
    else $error("strobes not low in power-down");
  AST_IDLE_STROBES: assert property (@(posedge clk_sys) disable iff (!resetn)
    idle |-> (ale_o && program_fetch_strobe_n))
    else $error("strobes not high in idle");
  AST_IDLE_ENTRY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sfr_wr && cpu_clk_en && sfr_addr == ppmc_pkg::PMC_ADDR && sfr_wdata == 8'h01 && !any_rst)
    |=> (mode == ppmc_pkg::PPMC_IDLE))
    else $error("idle not entered");
  AST_PDOWN_ENTRY: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sfr_wr && cpu_clk_en && sfr_addr == ppmc_pkg::PMC_ADDR && sfr_wdata[1] && !any_rst)
    |=> !osc_enable && !periph_clk_en)
    else $error("power-down not entered");
  AST_PDOWN_STAYS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (pdown && !any_rst) |=> pdown)
    else $error("power-down left without reset");
  AST_IDLE_WAKE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (idle && irq_pending) |=> !idle)
    else $error("idle not left on interrupt");
  AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (idle && $past(idle)) |-> $stable(p1_o) && $stable(p2_o))
    else $error("ports moved in idle");
  AST_RESET_CLEARS: assert property (@(posedge clk_sys) disable iff (!resetn)
    any_rst |=> (pmc == 8'h00))
    else $error("mode bits not cleared");
  AST_CS_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((idle || pdown) && !cfg1[ppmc_pkg::CFG1_CSGPIO_BIT]) |-> ext_code_chip_select_n)
    else $error("chip select active in low power");
  AST_P1_ADDR: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_clk_en && ext_access && ld_sel) |=> (p1_o == $past(ext_addr[7:0])))
    else $error("port one missing address");
  COV_IDLE: cover property (@(posedge clk_sys) disable iff (!resetn) idle ##1 !idle);
  COV_PDOWN: cover property (@(posedge clk_sys) disable iff (!resetn) pdown);
  COV_P2ADDR: cover property (@(posedge clk_sys) disable iff (!resetn) p2_addr_on);
  COV_SUSPECT: cover property (@(posedge clk_sys) disable iff (!resetn) adc_result_suspect);
  COV_CS_GPIO: cover property (@(posedge clk_sys) disable iff (!resetn)
    pdown && cfg1[ppmc_pkg::CFG1_CSGPIO_BIT]);
  AST_P1_LATCH: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_clk_en && !(ext_access && ld_sel)) |=> (p1_o == $past(port_one_latch)))
    else $error("port one lost its latch value");
  AST_P2_ADDR: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_clk_en && p2_addr_on) |=> (p2_o[6:0] == $past(ext_addr[14:8])))
    else $error("port two missing address");
  AST_P2_LATCH: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_clk_en && !p2_addr_on) |=> (p2_o == $past(port_two_latch)))
    else $error("port two lost its latch value");
  AST_P2_TOP_LATCH: assert property (@(posedge clk_sys) disable iff (!resetn)
    cpu_clk_en |=> (p2_o[7] == $past(port_two_latch[7])))
    else $error("port two bit 7 not from latch");
  AST_STRONG_RISE: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(p1_o[0]) |-> p1_strong[0])
    else $error("no strong drive on rising port bit");
  // Three high samples outlast any window of up to two cycles
  AST_STRONG_ENDS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (STRONG_CYC <= 2 && p1_o[0]) [*3] |-> !p1_strong[0])
    else $error("strong drive held past its window");
  AST_STRONG_ONE: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((p1_strong & ~p1_o) | (p2_strong & ~p2_o)) == 8'h00)
    else $error("strong drive on a low port bit");
  AST_IDLE_CLOCKS: assert property (@(posedge clk_sys) disable iff (!resetn)
    idle |-> (!cpu_clk_en && periph_clk_en && osc_enable))
    else $error("idle clock gating wrong");
  AST_PDOWN_CLOCKS: assert property (@(posedge clk_sys) disable iff (!resetn)
    pdown |-> (!cpu_clk_en && !periph_clk_en && !osc_enable))
    else $error("clock running in power-down");
  AST_CS_BASE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode == ppmc_pkg::PPMC_ACTIVE && !cfg1[ppmc_pkg::CFG1_CSGPIO_BIT] && eal_n)
    |-> (ext_code_chip_select_n == (ext_addr < ppmc_pkg::EXT_CS_BASE)))
    else $error("chip select wrong for code address");
  AST_CS_CODE_LOW: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode == ppmc_pkg::PPMC_ACTIVE && !cfg1[ppmc_pkg::CFG1_CSGPIO_BIT] && !eal_n)
    |-> !ext_code_chip_select_n)
    else $error("chip select inactive with code select low");
  AST_SUSPECT_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sfr_wr && cpu_clk_en && sfr_addr == ppmc_pkg::PMC_ADDR && adc_busy && !any_rst &&
    sfr_wdata[ppmc_pkg::PMC_IDLE_BIT]) |=> adc_result_suspect)
    else $error("conversion not flagged on idle entry");
  AST_WRITE_REFUSED: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!cpu_clk_en && !any_rst) |=> $stable(cfg1))
    else $error("register written with cpu clock gated");
endmodule : ppmc_top
`default_nettype wire

//--- tb/ppmc_ext_mem.sv
// Purpose: External program memory hanging off the port one / port two address pins
// Assumes: Address taken from the port pins while selected and fetched
// Notes: Released data bus shows the inverse of its last value, never a stale copy
`default_nettype none
module ppmc_ext_mem (
  input wire logic clk_sys, // System clock
  input wire logic [7:0] p1_o, // Low address byte
  input wire logic [7:0] p2_o, // Upper address bits 6:0
  input wire logic cs_n, // Chip select, active low
  input wire logic fetch_n, // Fetch strobe, active low
  output logic [7:0] code_byte, // Data bus to the core
  output logic [14:0] last_addr // Address of the last fetch seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] held = 8'h00;
  initial last_addr = 15'h7FFF;
  always @(posedge clk_sys) begin
    if (!cs_n && !fetch_n) begin
      last_addr <= {p2_o[6:0], p1_o};
      held <= p1_o ^ p2_o;
    end
  end
  // Unselected memory must not look like it still answers
  assign code_byte = (!cs_n && !fetch_n) ? (p1_o ^ p2_o) : ~held;
endmodule : ppmc_ext_mem
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench for port selection and power mode control
// Assumes: Pins settle through the two-flop synchronisers within four cycles
// Notes: Inputs change 1 to 4 ns after the rising edge
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STRONG = 2;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic int_reset = 1'b0, sfr_wr = 1'b0, ext_access = 1'b1, addr_is_15bit = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, port_zero_latch = 8'hC3;
  logic [7:0] port_one_latch = 8'h96, port_two_latch = 8'h81;
  logic [15:0] ext_addr = 16'h5A3C;
  logic ale_run = 1'b0, fetch_run = 1'b1, cs_gpio_out = 1'b1, irq_pending = 1'b0;
  logic port1_addr_emit_select = 1'b1, external_code_select_n = 1'b0;
  logic port_led_drive = 1'b0, adc_busy = 1'b1;
  // Every input stays driven, power-down included
  logic [3:0] serial_if_latch = 4'hA;
  logic [7:0] sfr_rdata, scan_drive, p1_o, p1_strong, p2_o, p2_strong, p1_pullup;
  logic [6:0] p2_pullup;
  logic [3:0] serial_if_oe;
  logic [1:0] mode_state;
  logic [14:0] mem_addr;
  logic port_led_pin_oe, ale_o, program_fetch_strobe_n, ext_code_chip_select_n;
  logic cpu_clk_en, periph_clk_en, osc_enable, adc_result_suspect;
  int errors = 0, checks_done = 0, cycles = 0, n;

  ppmc_top #(.STRONG_CYC(STRONG)) u_ppmc_top (.clk_sys, .resetn, .int_reset, .sfr_wr,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .port_zero_latch, .scan_drive, .port_one_latch,
    .port_two_latch, .ext_access, .ext_addr, .addr_is_15bit, .ale_run, .fetch_run,
    .cs_gpio_out, .port1_addr_emit_select, .external_code_select_n, .irq_pending, .p1_o,
    .p1_strong, .p2_o, .p2_strong, .p1_pullup, .p2_pullup, .port_led_pin_oe,
    .port_led_drive, .serial_if_latch, .serial_if_oe, .ale_o, .program_fetch_strobe_n,
    .ext_code_chip_select_n, .cpu_clk_en, .periph_clk_en, .osc_enable,
    .adc_result_suspect, .adc_busy, .mode_state);
  ppmc_ext_mem u_ppmc_ext_mem (.clk_sys, .p1_o, .p2_o, .cs_n(ext_code_chip_select_n),
    .fetch_n(program_fetch_strobe_n), .code_byte(), .last_addr(mem_addr));

  always #5 clk_sys = ~clk_sys;

  task automatic close_out();
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Whole run needs some 50 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc

  // Strobe for one edge, then a quiet edge so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    sfr_addr = a;
    #1;
    chk(what, exp, sfr_rdata);
  endtask : rdchk

  initial begin
    cyc(5);
    resetn = 1'b1;
    cyc(4);
    rdchk(ppmc_pkg::PMC_ADDR, 8'h00, "pmc reset");
    rdchk(ppmc_pkg::CFG1_ADDR, 8'h00, "cfg1 reset");
    rdchk(8'h55, 8'h00, "unmapped read");
    chk("scan drive", 8'hC3, scan_drive);
    chk("p1 pullup", 8'hFF, p1_pullup);
    chk("p2 pullup", 7'h7F, p2_pullup);
    chk("serial oe", 4'h5, serial_if_oe);
    chk("led oe", 1'b1, port_led_pin_oe);
    chk("p1 address", 8'h3C, p1_o);
    chk("p2 address", 8'hDA, p2_o);
    chk("memory address", 15'h5A3C, mem_addr);
    chk("cs code low", 1'b0, ext_code_chip_select_n);
    port1_addr_emit_select = 1'b0;
    external_code_select_n = 1'b1;
    ext_addr = 16'h3FFF;
    cyc(4);
    chk("p1 latch", 8'h96, p1_o);
    chk("p2 latch", 8'h81, p2_o);
    chk("cs below base", 1'b1, ext_code_chip_select_n);
    ext_addr = 16'h4000;
    cyc(2);
    chk("cs at base", 1'b0, ext_code_chip_select_n);
    wr(ppmc_pkg::CFG1_ADDR, 8'h01);
    cyc(1);
    chk("p2 enabled", 8'hC0, p2_o);
    chk("p2 strong", 8'h40, p2_strong);
    n = 0;
    port_one_latch = 8'h97;
    repeat (8) begin
      if (p1_strong[0] === 1'b1) n++;
      cyc(1);
    end
    chk("strong cycles", STRONG, n);
    chk("weak after", 1'b0, p1_strong[0]);
    wr(ppmc_pkg::PMC_ADDR, 8'h01);
    chk("idle mode", 2'd1, mode_state);
    chk("idle clocks", 3'b011, {cpu_clk_en, periph_clk_en, osc_enable});
    chk("idle strobes", 2'b11, {ale_o, program_fetch_strobe_n});
    chk("adc suspect", 1'b1, adc_result_suspect);
    port_one_latch = 8'h10;
    wr(ppmc_pkg::CFG1_ADDR, 8'h08);
    cyc(2);
    chk("idle p1 held", 8'h97, p1_o);
    rdchk(ppmc_pkg::CFG1_ADDR, 8'h01, "idle write refused");
    irq_pending = 1'b1;
    cyc(2);
    irq_pending = 1'b0;
    cyc(1);
    chk("irq wake", 2'd0, mode_state);
    ale_run = 1'b1;
    fetch_run = 1'b0;
    wr(ppmc_pkg::PMC_ADDR, 8'h02);
    chk("pdown mode", 2'd2, mode_state);
    chk("pdown clocks", 3'b000, {cpu_clk_en, periph_clk_en, osc_enable});
    chk("pdown strobes", 2'b00, {ale_o, program_fetch_strobe_n});
    chk("pdown cs", 1'b1, ext_code_chip_select_n);
    irq_pending = 1'b1;
    cyc(2);
    irq_pending = 1'b0;
    chk("irq no wake", 2'd2, mode_state);
    int_reset = 1'b1;
    cyc(1);
    int_reset = 1'b0;
    cyc(1);
    chk("int reset wake", 2'd0, mode_state);
    chk("active strobes", 2'b11, {ale_o, program_fetch_strobe_n});
    rdchk(ppmc_pkg::PMC_ADDR, 8'h00, "pmc after int reset");
    wr(ppmc_pkg::CFG1_ADDR, 8'h08);
    cs_gpio_out = 1'b0;
    wr(ppmc_pkg::PMC_ADDR, 8'h02);
    chk("pdown cs gpio", 1'b0, ext_code_chip_select_n);
    resetn = 1'b0;
    cyc(3);
    resetn = 1'b1;
    cyc(1);
    chk("pin reset wake", 2'd0, mode_state);
    rdchk(ppmc_pkg::CFG1_ADDR, 8'h00, "cfg1 after reset");
    close_out();
  end
endmodule : tb
`default_nettype wire
